// file: src/rxf_top.sv
// Purpose: receive fifo write side with error and overflow drop,
//          read side rewind, apb control and status
// Assumes: mac and usb sides run on core_clk
// Notes:   one status slot leads each frame in the fifo
`timescale 1ns/1ns
`include "rxf_defs.svh"
module rxf_top
  import rxf_pkg::*;
#(
  parameter int DEPTH = 5120,
  parameter int CW    = 16
)(
  input  wire logic        core_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic        pready,
  output      logic [31:0] prdata,
  output      logic        pslverr,
  // mac side
  input  wire logic        mac_sof,
  input  wire logic        mac_valid,
  input  wire logic [31:0] mac_data,
  input  wire logic        mac_eof,
  input  wire logic [13:0] mac_len,
  input  wire logic [15:0] mac_len_type,
  input  wire logic        mac_crc_err,
  input  wire logic        mac_late_col,
  input  wire logic        mac_rx_er,
  input  wire logic [2:0]  mac_drib_bits,
  input  wire logic        mac_speed_10m,
  input  wire logic        mac_bcast,
  input  wire logic        mac_mcast,
  input  wire logic        mac_filt_fail,
  input  wire logic        mac_len_mismatch,
  output      logic        frame_drop,
  // usb transmit side
  input  wire logic        usb_rd_req,
  input  wire logic        usb_mark,
  input  wire logic        usb_rewind,
  output      logic [31:0] usb_rd_data,
  output      logic        usb_rd_valid,
  output      logic        usb_avail
);
  localparam int AW = $clog2(DEPTH);

  // ========================================================
  // pointer helpers
  function automatic logic [AW-1:0] ptr_next(
    input logic [AW-1:0] p
  );
    ptr_next = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : ptr_next

  function automatic logic [AW-1:0] ptr_dist(
    input logic [AW-1:0] a,
    input logic [AW-1:0] b
  );
    ptr_dist = (a >= b) ? a - b : AW'(DEPTH) - b + a;
  endfunction : ptr_dist

  // ========================================================
  // storage and state
  logic [31:0]   mem [DEPTH];
  rxf_state_t    state;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] hdr_ptr;
  logic [AW-1:0] commit_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] rd_mark;
  logic [CW-1:0] ovf_count;
  logic [1:0]    ctrl;
  logic [31:0]   last_status;
  logic [31:0]   st_word;
  logic          full_now;
  logic          no_hdr_room;
  logic          data_take;
  logic          ovf_hit;
  logic          eof_take;
  logic          err_drop;
  logic          eof_keep;
  logic          mem_we;
  logic [AW-1:0] mem_waddr;
  logic [31:0]   mem_wdata;
  logic          rd_take;

  // ========================================================
  // status word
  rxf_status_enc u_enc (
    .len          (mac_len),
    .len_type     (mac_len_type),
    .crc_err      (mac_crc_err),
    .late_col     (mac_late_col),
    .rx_er        (mac_rx_er),
    .drib_bits    (mac_drib_bits),
    .speed_10m    (mac_speed_10m),
    .bcast        (mac_bcast),
    .mcast        (mac_mcast),
    .filt_fail    (mac_filt_fail),
    .len_mismatch (mac_len_mismatch),
    .word         (st_word)
  );

  // ========================================================
  // write side decisions
  // space is freed only when the usb side marks a packet done
  assign full_now    = ptr_dist(wr_ptr, rd_mark)
                     == AW'(DEPTH - 1);
  assign no_hdr_room = ptr_dist(commit_ptr, rd_mark)
                     == AW'(DEPTH - 1);
  assign data_take   = (state == rxf_recv) && mac_valid
                     && !mac_eof && !mac_sof;
  assign ovf_hit     = (data_take && full_now)
                     || (mac_sof && no_hdr_room);
  assign eof_take    = (state == rxf_recv) && mac_eof
                     && !mac_sof;
  assign err_drop    = (ctrl[`RXF_CTRL_DISC]
                     && st_word[`RXF_ST_ERRSUM])
                     || (st_word[`RXF_ST_RUNT]
                     && !ctrl[`RXF_CTRL_PASS]);
  assign eof_keep    = eof_take && !err_drop;

  assign mem_we    = (data_take && !full_now) || eof_keep;
  assign mem_waddr = eof_keep ? hdr_ptr : wr_ptr;
  assign mem_wdata = eof_keep ? st_word : mac_data;

  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // ========================================================
  // write side state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= rxf_idle;
    end else if (mac_sof) begin
      state <= no_hdr_room ? rxf_skip : rxf_recv;
    end else begin
      case (state)
        rxf_idle: begin
          state <= rxf_idle;
        end
        rxf_recv: begin
          if (ovf_hit) begin
            state <= rxf_skip;
          end else if (mac_eof) begin
            state <= rxf_idle;
          end
        end
        rxf_skip: begin
          if (mac_eof) begin
            state <= rxf_idle;
          end
        end
        default: begin
          state <= rxf_idle;
        end
      endcase
    end
  end

  // ========================================================
  // write pointers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr     <= '0;
      hdr_ptr    <= '0;
      commit_ptr <= '0;
    end else if (mac_sof) begin
      // an unfinished frame is abandoned by restarting here
      hdr_ptr <= commit_ptr;
      wr_ptr  <= no_hdr_room ? commit_ptr
               : ptr_next(commit_ptr);
    end else if (ovf_hit) begin
      wr_ptr <= hdr_ptr;
    end else if (data_take) begin
      wr_ptr <= ptr_next(wr_ptr);
    end else if (eof_take) begin
      if (err_drop) begin
        wr_ptr <= hdr_ptr;
      end else begin
        commit_ptr <= wr_ptr;
      end
    end
  end

  // ========================================================
  // overflow count, last status, drop pulse
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ovf_count <= '0;
    end else if (ovf_hit) begin
      ovf_count <= ovf_count + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_status <= 32'h0000_0000;
    end else if (eof_take) begin
      last_status <= st_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      frame_drop <= 1'b0;
    end else begin
      frame_drop <= ovf_hit || (eof_take && err_drop);
    end
  end

  // ========================================================
  // read side with rewind
  assign rd_take = usb_rd_req && !usb_rewind
                 && (rd_ptr != commit_ptr);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_ptr  <= '0;
      rd_mark <= '0;
    end else begin
      if (usb_rewind) begin
        rd_ptr <= rd_mark;
      end else if (rd_take) begin
        rd_ptr <= ptr_next(rd_ptr);
      end
      if (usb_mark && !usb_rewind) begin
        rd_mark <= rd_ptr;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      usb_rd_data  <= 32'h0000_0000;
      usb_rd_valid <= 1'b0;
      usb_avail    <= 1'b0;
    end else begin
      usb_rd_valid <= rd_take;
      usb_avail    <= rd_ptr != commit_ptr;
      if (rd_take) begin
        usb_rd_data <= mem[rd_ptr];
      end
    end
  end

  // ========================================================
  // apb slave, ready one cycle into the access phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        case (paddr)
          `RXF_REG_CTRL:  prdata <= {30'h0, ctrl};
          `RXF_REG_OVF:   prdata <= 32'(ovf_count);
          `RXF_REG_STAT:  prdata <= last_status;
          `RXF_REG_LEVEL: prdata <=
            32'(ptr_dist(commit_ptr, rd_ptr));
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl <= `RXF_CTRL_RST;
    end else if (psel && penable && pready && pwrite
                 && paddr == `RXF_REG_CTRL) begin
      ctrl <= pwdata[1:0];
    end
  end

  // ========================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  drop_err_a : assert property (
    eof_take && err_drop |=> wr_ptr == $past(hdr_ptr)
      && commit_ptr == $past(commit_ptr))
    else $error("errored frame not dropped");
  keep_frame_a : assert property (
    eof_keep |=> commit_ptr == $past(wr_ptr))
    else $error("kept frame not committed");
  ovf_drop_a : assert property (
    data_take && full_now |=> state == rxf_skip
      && wr_ptr == $past(hdr_ptr))
    else $error("overflow did not rewind frame");
  ovf_count_a : assert property (
    ovf_hit |=> ovf_count == $past(ovf_count) + 1'b1)
    else $error("overflow not counted");
  skip_quiet_a : assert property (
    state == rxf_skip && !mac_sof |-> !mem_we
      ##1 $stable(wr_ptr) || $past(mac_sof))
    else $error("write during skipped frame");
  rd_rewind_a : assert property (
    usb_rewind |=> rd_ptr == $past(rd_mark))
    else $error("read rewind failed");
  hdr_status_a : assert property (
    eof_keep |-> mem_we && mem_waddr == hdr_ptr
      && mem_wdata == st_word)
    else $error("status not at header slot");
  err_summary_a : assert property (
    st_word[`RXF_ST_ERRSUM] == (st_word[`RXF_ST_RUNT]
      | st_word[`RXF_ST_LONG] | st_word[`RXF_ST_LATE]
      | st_word[`RXF_ST_CRC]))
    else $error("error summary mismatch");

  resv_zero_a : assert property (
    st_word[31] == 1'b0 && st_word[14] == 1'b0
      && st_word[9:8] == 2'h0 && st_word[0] == 1'b0)
    else $error("reserved status bit set");

  drib_late_a : assert property (
    st_word[`RXF_ST_LATE] |-> !st_word[`RXF_ST_DRIB])
    else $error("dribble with late collision");

  hidden_a : assert property (
    usb_rd_valid |-> $past(rd_ptr) != $past(commit_ptr))
    else $error("uncommitted word read");

  frame_kept_c : cover property (
    eof_keep ##[1:20] usb_rd_valid);
  overflow_c   : cover property (ovf_hit ##[1:50] mac_sof);
  rewind_c     : cover property (
    usb_rd_valid ##1 usb_rewind ##1 rd_take);
endmodule : rxf_top

// file: src/rxf_defs.svh
// Purpose: constants of the receive fifo error and drop block
// Assumes: included by bare name
// Notes:   definitions only
`ifndef RXF_DEFS_SVH
`define RXF_DEFS_SVH
// ==========================================================
// status word fields
`define RXF_ST_FILT    30
`define RXF_ST_LEN_HI  29
`define RXF_ST_LEN_LO  16
`define RXF_ST_ERRSUM  15
`define RXF_ST_BCAST   13
`define RXF_ST_LENERR  12
`define RXF_ST_RUNT    11
`define RXF_ST_MCAST   10
`define RXF_ST_LONG    7
`define RXF_ST_LATE    6
`define RXF_ST_FTYPE   5
`define RXF_ST_WDOG    4
`define RXF_ST_MII     3
`define RXF_ST_DRIB    2
`define RXF_ST_CRC     1
// ==========================================================
// frame size limits in bytes, type threshold and dribble bit counts
`define RXF_RUNT_BYTES 14'h0040
`define RXF_MAX_BYTES  14'h05ee
`define RXF_WDOG_BYTES 14'h0800
`define RXF_HDR_BYTES  14'h000e
`define RXF_TYPE_MIN   16'h05dc
`define RXF_DRIB_MII   3'h4
`define RXF_DRIB_10M   3'h3
// ==========================================================
// apb register map
`define RXF_REG_CTRL   8'h00
`define RXF_REG_OVF    8'h04
`define RXF_REG_STAT   8'h08
`define RXF_REG_LEVEL  8'h0c
`define RXF_CTRL_DISC  0
`define RXF_CTRL_PASS  1
`define RXF_CTRL_RST   2'h0
`endif

// file: src/rxf_pkg.sv
// Purpose: types of the receive fifo error and drop block
// Assumes: none
// Notes:   write side states are gray along idle, recv, skip
package rxf_pkg;
  typedef enum logic [1:0] {
    rxf_idle = 2'h0,
    rxf_recv = 2'h1,
    rxf_skip = 2'h3
  } rxf_state_t;
endpackage : rxf_pkg

// file: src/rxf_status_enc.sv
// Purpose: builds the 32 bit receive status word from mac flags
// Assumes: inputs are stable in the cycle the frame ends
// Notes:   purely combinational
`timescale 1ns/1ns
`include "rxf_defs.svh"
module rxf_status_enc
  import rxf_pkg::*;
(
  input  wire logic [13:0] len,
  input  wire logic [15:0] len_type,
  input  wire logic        crc_err,
  input  wire logic        late_col,
  input  wire logic        rx_er,
  input  wire logic [2:0]  drib_bits,
  input  wire logic        speed_10m,
  input  wire logic        bcast,
  input  wire logic        mcast,
  input  wire logic        filt_fail,
  input  wire logic        len_mismatch,
  output      logic [31:0] word
);
  logic runt;
  logic too_long;
  logic wdog;
  logic ftype;
  logic drib;
  logic crc;

  assign runt     = len < `RXF_RUNT_BYTES;
  assign too_long = len > `RXF_MAX_BYTES;
  assign wdog     = len > `RXF_WDOG_BYTES;
  // no type decision for frames shorter than the header
  assign ftype    = (len >= `RXF_HDR_BYTES)
                  && (len_type > `RXF_TYPE_MIN);
  // dribble is suppressed by a late collision
  assign drib     = !late_col && (speed_10m ?
                    (drib_bits >= `RXF_DRIB_10M) :
                    (drib_bits == `RXF_DRIB_MII));
  assign crc      = crc_err | rx_er;

  always_comb begin
    word                                   = 32'h0000_0000;
    word[`RXF_ST_FILT]                     = filt_fail;
    word[`RXF_ST_LEN_HI:`RXF_ST_LEN_LO]    = len;
    word[`RXF_ST_ERRSUM] = runt | too_long | late_col | crc;
    word[`RXF_ST_BCAST]                    = bcast;
    word[`RXF_ST_MCAST]                    = mcast;
    word[`RXF_ST_LENERR]                   = len_mismatch;
    word[`RXF_ST_RUNT]                     = runt;
    word[`RXF_ST_LONG]                     = too_long;
    word[`RXF_ST_LATE]                     = late_col;
    word[`RXF_ST_FTYPE]                    = ftype;
    word[`RXF_ST_WDOG]                     = wdog;
    word[`RXF_ST_MII]                      = rx_er;
    word[`RXF_ST_DRIB]                     = drib;
    word[`RXF_ST_CRC]                      = crc;
  end
endmodule : rxf_status_enc

// file: tb/rxf_partner.sv
// Purpose: mac receive side and usb bulk-in reader model
// Assumes: single core_clk domain, signals change after rising edges
// Notes:   status lines show inverted values after the eof cycle
`timescale 1ns/1ns
module rxf_partner (
  input  wire logic        core_clk,
  output      logic        mac_sof,
  output      logic        mac_valid,
  output      logic [31:0] mac_data,
  output      logic        mac_eof,
  output      logic [13:0] mac_len,
  output      logic [15:0] mac_len_type,
  output      logic        mac_crc_err,
  output      logic        mac_late_col,
  output      logic        mac_rx_er,
  output      logic [2:0]  mac_drib_bits,
  output      logic        mac_speed_10m,
  output      logic        mac_bcast,
  output      logic        mac_mcast,
  output      logic        mac_filt_fail,
  output      logic        mac_len_mismatch,
  output      logic        usb_rd_req,
  output      logic        usb_mark,
  output      logic        usb_rewind,
  input  wire logic [31:0] usb_rd_data,
  input  wire logic        usb_rd_valid
);
  logic [40:0] st;
  assign {mac_len, mac_len_type, mac_crc_err, mac_late_col, mac_rx_er,
          mac_drib_bits, mac_speed_10m, mac_bcast, mac_mcast,
          mac_filt_fail, mac_len_mismatch} = st;
  initial begin
    {mac_sof, mac_valid, mac_eof, usb_rd_req, usb_mark, usb_rewind} = '0;
    mac_data = 32'h0;
    st = '0;
  end
  // ==========================================================
  // mac frame: sof, nw data words, eof carrying the status flags
  task automatic frame(input int nw, input logic [40:0] s);
    @(posedge core_clk);
    mac_sof <= 1'b1;
    @(posedge core_clk);
    mac_sof <= 1'b0;
    for (int i = 0; i < nw; i++) begin
      mac_valid <= 1'b1;
      mac_data  <= 32'h00a0_0000 | i;
      @(posedge core_clk);
    end
    mac_valid <= 1'b0;
    mac_eof   <= 1'b1;
    st        <= s;
    @(posedge core_clk);
    mac_eof  <= 1'b0;
    st       <= ~s;
    mac_data <= ~mac_data;
  endtask : frame
  // ==========================================================
  // usb side: one word read, mark or rewind pulse
  task automatic read(output logic [31:0] d, output logic ok);
    ok = 1'b0;
    d  = 32'h0;
    @(posedge core_clk);
    usb_rd_req <= 1'b1;
    @(posedge core_clk);
    usb_rd_req <= 1'b0;
    for (int n = 0; n < 8 && !ok; n++) begin
      #1;
      if (usb_rd_valid === 1'b1) begin
        ok = 1'b1;
        d  = usb_rd_data;
      end else @(posedge core_clk);
    end
  endtask : read
  task automatic strobe(input logic rw);
    @(posedge core_clk);
    if (rw) usb_rewind <= 1'b1;
    else usb_mark <= 1'b1;
    @(posedge core_clk);
    {usb_mark, usb_rewind} <= 2'h0;
  endtask : strobe
endmodule : rxf_partner

// file: tb/rxf_top_tb.sv
// Purpose: self-checking bench of the receive fifo error and drop block
// Assumes: depth shortened to 16 words
// Notes:   partner model drives mac and usb sides
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  miscompares++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
  end end
module rxf_top_tb;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        mac_sof, mac_valid, mac_eof, mac_crc_err, mac_late_col;
  logic        mac_rx_er, mac_speed_10m, mac_bcast, mac_mcast, ok, er;
  logic        mac_filt_fail, mac_len_mismatch, frame_drop, usb_rd_req;
  logic        usb_mark, usb_rewind, usb_rd_valid, usb_avail;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, mac_data, usb_rd_data, d, e;
  logic [13:0] mac_len;
  logic [15:0] mac_len_type;
  logic [2:0]  mac_drib_bits;
  logic [40:0] tbl [5];
  int          miscompares, n_compared, drops;
  rxf_top #(.DEPTH(16)) dut (.*);
  rxf_partner p (.*);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (frame_drop === 1'b1) drops++;
  // ==========================================================
  // helpers
  task automatic stop_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      miscompares++;
      stop_test();
    end else begin
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'h0;
    end
  endtask : apb
  function automatic logic [31:0] exp_st(input logic [40:0] s);
    logic [13:0] l;
    logic [15:0] t;
    logic [2:0]  db;
    logic        c, lc, rx, s10, bc, mc, ff, lm;
    logic [31:0] r;
    {l, t, c, lc, rx, db, s10, bc, mc, ff, lm} = s;
    r = 32'h0;
    r[30] = ff;
    r[29:16] = l;
    {r[13], r[12], r[10], r[6], r[3]} = {bc, lm, mc, lc, rx};
    r[11] = l < 14'h0040;
    r[7] = l > 14'h05ee;
    r[5] = t > 16'h05dc && l >= 14'h000e;
    r[4] = l > 14'h0800;
    r[2] = !lc && (s10 ? db >= 3'h3 : db == 3'h4);
    r[1] = c | rx;
    r[15] = r[11] | r[7] | r[6] | r[1];
    return r;
  endfunction : exp_st
  // ==========================================================
  // scenarios
  task automatic t_regs;
    apb(1'b0, 8'h00, 32'h0, d);
    `CHK("ctrl reset", 32'h0, d)
    apb(1'b1, 8'h04, 32'h5, d);
    apb(1'b0, 8'h04, 32'h0, d);
    `CHK("ovf ro", 32'h0, d)
    apb(1'b0, 8'h10, 32'h0, d);
    `CHK("unmapped err", 1'b1, er)
  endtask : t_regs
  task automatic t_status;
    apb(1'b1, 8'h00, 32'h2, d);
    foreach (tbl[i]) begin
      e = exp_st(tbl[i]);
      p.frame(1, tbl[i]);
      apb(1'b0, 8'h0c, 32'h0, d);
      `CHK("level", 32'h2, d)
      `CHK("avail", 1'b1, usb_avail)
      apb(1'b0, 8'h08, 32'h0, d);
      `CHK("stat reg", e, d)
      p.read(d, ok);
      `CHK("read valid", 1'b1, ok)
      `CHK("status word", e, d)
      `CHK("status flags", e[7:1], d[7:1])
      `CHK("runt crc mii", e[11:1], d[11:1])
      p.read(d, ok);
      `CHK("data word", 32'h00a0_0000, d)
      p.strobe(1'b0);
      `CHK("avail empty", 1'b0, usb_avail)
    end
  endtask : t_status
  task automatic t_drops;
    apb(1'b1, 8'h00, 32'h0, d);
    p.frame(2, tbl[1]);
    apb(1'b1, 8'h00, 32'h1, d);
    p.frame(2, tbl[3]);
    apb(1'b0, 8'h0c, 32'h0, d);
    `CHK("drops", 2, drops)
    `CHK("level dropped", 32'h0, d)
    p.frame(20, tbl[0]);
    apb(1'b0, 8'h04, 32'h0, d);
    `CHK("ovf count", 32'h1, d)
    `CHK("ovf drop", 3, drops)
    p.frame(2, tbl[0]);
    apb(1'b0, 8'h0c, 32'h0, d);
    `CHK("level after ovf", 32'h3, d)
  endtask : t_drops
  task automatic t_rewind;
    p.read(d, ok);
    `CHK("first read", exp_st(tbl[0]), d)
    p.read(d, ok);
    p.strobe(1'b1);
    p.read(d, ok);
    `CHK("rewound read", exp_st(tbl[0]), d)
    `CHK("rewound valid", 1'b1, ok)
  endtask : t_rewind
  // ==========================================================
  // main sequence
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    // len, len_type, {crc, late, rx_er}, dribble, {10m, bc, mc, ff, lm}
    tbl[0] = {14'h0064, 16'h0800, 3'h0, 3'h4, 5'h08};
    tbl[1] = {14'h0028, 16'h0800, 3'h0, 3'h0, 5'h07};
    tbl[2] = {14'h000a, 16'h0800, 3'h4, 3'h3, 5'h10};
    tbl[3] = {14'h0640, 16'h0040, 3'h3, 3'h4, 5'h01};
    tbl[4] = {14'h0834, 16'h0400, 3'h0, 3'h7, 5'h12};
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_status();
    t_drops();
    t_rewind();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    stop_test();
  end
endmodule : rxf_top_tb
